// ### hdl/amp_cfg_pkg.sv
/*
  Constants shared by the amplifier configuration register bank:
  register offsets, writable masks, reset values, field positions,
  timing figures and the power sequencer states.
  Assumes a single system clock at 20 MHz.
*/
package amp_cfg_pkg;

  // ************************************************************
  // register offsets (word index on the control port)
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_FILT_DBG = 12'h506;
  localparam logic [11:0] OFS_ACC_LO = 12'h509;
  localparam logic [11:0] OFS_ACC_HI = 12'h50A;
  localparam logic [11:0] OFS_COMP_OUT = 12'h50B;
  localparam logic [11:0] OFS_STAT0 = 12'h50C;
  localparam logic [11:0] OFS_STAT1 = 12'h50D;
  localparam logic [11:0] OFS_STAT2 = 12'h50E;
  localparam logic [11:0] OFS_STAT3 = 12'h50F;
  localparam logic [11:0] OFS_ADC_OFS = 12'h510;
  localparam logic [11:0] OFS_OUT_OFS = 12'h511;
  localparam logic [11:0] OFS_DELAY = 12'h520;
  localparam logic [11:0] OFS_ENCLK = 12'h521;
  localparam logic [11:0] OFS_MIXER = 12'h522;
  localparam logic [11:0] OFS_ANALOG = 12'h523;
  localparam logic [11:0] OFS_SPORT = 12'h524;

  // ************************************************************
  // writable masks and reset values
  // ************************************************************
  localparam logic [31:0] COMP_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] ENCLK_MASK = 32'h000F_FFFF;
  localparam logic [31:0] MIXER_MASK = 32'h0F0F_3FFF;
  localparam logic [31:0] ANALOG_MASK = 32'h0100_1FFF;
  localparam logic [31:0] SPORT_MASK = 32'h3F0F_3FFF;
  localparam logic [31:0] DELAY_RST = 32'h0120_000A;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PUD_LSB = 0;
  localparam int DEGLITCH_LSB = 16;
  localparam int STD_LSB = 24;
  localparam int EN_BIT = 0;
  localparam int FORCE_BIT = 1;
  localparam int PULSE_BIT = 2;
  localparam int VREF_BIT = 3;
  localparam int OUTCORR_BIT = 4;
  localparam int ADCCAL_BIT = 5;
  localparam int ADCCORR_BIT = 6;
  localparam int PLLDIV_LSB = 8;
  localparam int PLLSRC_BIT = 11;
  localparam int PMCSEL_BIT = 12;
  localparam int HIGH_FIDELITY_MODE_BIT = 13;
  localparam int PCSTOP_BIT = 14;
  localparam int HPFMODE_LSB = 16;
  localparam int HPFON_BIT = 19;
  localparam int ADCGAIN_LSB = 0;
  localparam int MUTE_BIT = 6;
  localparam int ZX_BIT = 7;
  localparam int SERGAIN_LSB = 8;
  localparam int SER2DSP_BIT = 16;
  localparam int ADC2DSP_BIT = 17;
  localparam int TXSRC_LSB = 18;
  localparam int CH1_LSB = 24;
  localparam int CH2_LSB = 26;
  localparam int PAR_BIT = 2;
  localparam int ZANA_BIT = 3;
  localparam int ZDIG_BIT = 4;
  localparam int AUTOSD_BIT = 6;
  localparam int SCOFF_BIT = 9;
  localparam int THOFF_BIT = 10;
  localparam int SEMOD_BIT = 12;

  // ************************************************************
  // codes and timing
  // ************************************************************
  localparam logic [2:0] PLL_DIV_MAX = 3'h4;
  localparam logic [1:0] TX_NONE = 2'h0;
  localparam logic [1:0] TX_BAD = 2'h3;
  localparam logic [8:0] GAIN_ZERO_CODE = 9'h033;
  localparam logic [8:0] GAIN_STEP_HALF_DB = 9'h003;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SEQ_BOOT, SEQ_STANDBY, SEQ_RAMP_UP, SEQ_ON, SEQ_RAMP_DOWN
  } seq_state_e;

endpackage

// ### hdl/amp_dsp_config_debug_regs.sv
/*
  Configuration, mixer and debug register bank of the stereo class D
  amplifier, with the enable source logic and power sequencer it steers.
  Assumes a word-wide register port driven by the two-wire control engine,
  status inputs on clk_sys except the shutdown pin, which is asynchronous.
*/
//
// How it works
// - in manual mode the enable bit turns the device on or off
// - force bit picks the enable source: shutdown pin or register bit
// - pulse bit: pin needs a stable level, or a pulse toggles enable
// - sequencer advances after state delay, or waits for stable reference
// - delay word holds power-up delay, state delay and a deglitch field that the pin filter never uses
// - three bits pick the PLL input divider, codes above 100 unused
// - bit 11 picks PLL source, bit 12 picks power management clock
// - high fidelity bit forces a 4096fs PLL output
// - processor clock stops after configuration when its stop bit is set
// - high-pass filter enable bit and three-bit filter mode
// - three bits enable offset correction, calibration and correction
// - both path gains: code 0 is -76.5 dB, 1.5 dB steps, 0x33 is 0 dB
// - mixer bit 6 mutes, bit 7 turns zero crossing detection off
// - two bits pass serial and ADC audio into the processor
// - transmitter source: none, ADC, processor; code 11 unused
// - each output channel source: off, processor, serial, ADC
// - silence on analog or serial input can auto-disable the amplifiers
// - faults can disable amplifiers; short and thermal guards can be off
// - parallel output mode and single edge modulation bits
// - compressor word reads a 24-bit sample, upper bits zero
// - four read-only 32-bit statistics words
// - offset words: right/channel 1 low half, left/channel 2 high half
`timescale 1ns/1ps
`default_nettype none
module amp_dsp_config_debug_regs
  import amp_cfg_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic shutdown_n_pin, // shutdown pin, asynchronous
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [ADDR_W-1:0] reg_addr, // register index
  input wire logic [31:0] reg_wdata, // write data
  output logic [31:0] reg_rdata, // read data
  output logic reg_rd_valid, // read data valid pulse
  input wire logic [31:0] filt_dbg_in, // filter debug data
  input wire logic [31:0] acc_lo_in, // accumulator low word
  input wire logic [31:0] acc_hi_in, // accumulator high word
  input wire logic [23:0] comp_in, // compressor output sample
  input wire logic [127:0] stat_in, // four statistics counts
  input wire logic vref_stable, // reference reports stable
  input wire logic analog_present, // analog input detected
  input wire logic serial_present, // serial audio present
  input wire logic short_fault, // output short detected
  input wire logic thermal_fault, // over temperature
  output logic amp_enable, // amplifiers running
  output logic dev_enabled, // sequencer in on state
  output logic proc_clk_en, // processor clock runs
  output logic [2:0] pll_div_sel, // PLL input divider code
  output logic pll_div_ok, // divider code is a defined one
  output logic pll_src_bclk, // PLL from serial bit clock
  output logic pmc_clk_ext, // power management on PLL source
  output logic high_fidelity_mode, // PLL fixed at 4096fs
  output logic adc_highpass_on, // ADC high-pass enabled
  output logic [2:0] adc_highpass_mode, // high-pass mode
  output logic output_offset_correct, // output offset correction
  output logic adc_offset_calibrate, // ADC offset calibration
  output logic adc_offset_correct, // ADC offset correction
  output logic signed [8:0] adc_gain_hdb, // ADC gain, half dB
  output logic signed [8:0] serial_gain_hdb, // serial gain, half dB
  output logic output_mute, // output muted
  output logic zero_cross_off, // zero crossing detect off
  output logic serial_to_dsp, // serial audio to processor
  output logic adc_to_dsp, // ADC audio to processor
  output logic [1:0] transmitter_source, // transmitter source
  output logic [1:0] channel1_source, // channel 1 source
  output logic [1:0] channel2_source, // channel 2 source
  output logic parallel_mode, // channels in parallel
  output logic single_edge_modulation, // single edge modulation
  output logic short_protect_on, // short protection active
  output logic thermal_protect_on, // thermal shutdown active
  output logic [15:0] adc_right_offset, // ADC right offset
  output logic [15:0] adc_left_offset, // ADC left offset
  output logic [15:0] channel1_offset, // channel 1 offset
  output logic [15:0] channel2_offset, // channel 2 offset
  output logic [31:0] sport_cfg // serial port config word
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic signed [8:0] gain_hdb(input logic [5:0] code);
    logic [8:0] d;
    d = {3'h0, code} - GAIN_ZERO_CODE;
    return $signed(9'(d * GAIN_STEP_HALF_DB));
  endfunction

  // ************************************************************
  // register storage and decode
  // ************************************************************
  logic [31:0] adc_ofs_reg, out_ofs_reg, delay_reg, enclk_reg;
  logic [31:0] mixer_reg, analog_reg, sport_reg;
  logic [31:0] rdata_reg, rd_mux;
  logic rd_valid_reg;

  wire wr_adc_ofs = reg_wr && (reg_addr == OFS_ADC_OFS);
  wire wr_out_ofs = reg_wr && (reg_addr == OFS_OUT_OFS);
  wire wr_delay = reg_wr && (reg_addr == OFS_DELAY);
  wire wr_enclk = reg_wr && (reg_addr == OFS_ENCLK);
  wire wr_mixer = reg_wr && (reg_addr == OFS_MIXER);
  wire wr_analog = reg_wr && (reg_addr == OFS_ANALOG);
  wire wr_sport = reg_wr && (reg_addr == OFS_SPORT);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      adc_ofs_reg <= CFG_RST;
      out_ofs_reg <= CFG_RST;
      delay_reg <= DELAY_RST;
      enclk_reg <= CFG_RST;
      mixer_reg <= CFG_RST;
      analog_reg <= CFG_RST;
      sport_reg <= CFG_RST;
    end else begin
      if (wr_adc_ofs) adc_ofs_reg <= reg_wdata;
      if (wr_out_ofs) out_ofs_reg <= reg_wdata;
      if (wr_delay) delay_reg <= reg_wdata;
      if (wr_enclk) enclk_reg <= reg_wdata & ENCLK_MASK;
      if (wr_mixer) mixer_reg <= reg_wdata & MIXER_MASK;
      if (wr_analog) analog_reg <= reg_wdata & ANALOG_MASK;
      if (wr_sport) sport_reg <= reg_wdata & SPORT_MASK;
    end
  end

  // read-only words are sampled live; a read of them never alters them
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      OFS_FILT_DBG: rd_mux = filt_dbg_in;
      OFS_ACC_LO: rd_mux = acc_lo_in;
      OFS_ACC_HI: rd_mux = acc_hi_in;
      OFS_COMP_OUT: rd_mux = {8'h00, comp_in} & COMP_MASK;
      OFS_STAT0: rd_mux = stat_in[31:0];
      OFS_STAT1: rd_mux = stat_in[63:32];
      OFS_STAT2: rd_mux = stat_in[95:64];
      OFS_STAT3: rd_mux = stat_in[127:96];
      OFS_ADC_OFS: rd_mux = adc_ofs_reg;
      OFS_OUT_OFS: rd_mux = out_ofs_reg;
      OFS_DELAY: rd_mux = delay_reg;
      OFS_ENCLK: rd_mux = enclk_reg;
      OFS_MIXER: rd_mux = mixer_reg;
      OFS_ANALOG: rd_mux = analog_reg;
      OFS_SPORT: rd_mux = sport_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_rd;
      if (reg_rd) rdata_reg <= rd_mux;
    end
  end

  // ************************************************************
  // shutdown pin and enable source
  // ************************************************************
  logic [2:0] pin_s_reg;
  logic pin_level_reg, pulse_en_reg;

  // a change counts only once the second and third stages agree
  wire pin_agree = (pin_s_reg[1] == pin_s_reg[2]);
  wire pin_rise = pin_agree && pin_s_reg[2] && !pin_level_reg;
  wire force_reg_src = enclk_reg[FORCE_BIT];
  wire pulse_mode = enclk_reg[PULSE_BIT];
  wire pin_req = pulse_mode ? pulse_en_reg : pin_level_reg;
  wire enable_req = force_reg_src ? enclk_reg[EN_BIT] : pin_req;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s_reg <= 3'h0;
      pin_level_reg <= 1'b0;
      pulse_en_reg <= 1'b0;
    end else begin
      pin_s_reg <= {pin_s_reg[1:0], shutdown_n_pin};
      if (pin_agree) pin_level_reg <= pin_s_reg[2];
      if (pin_rise && pulse_mode) pulse_en_reg <= !pulse_en_reg;
    end
  end

  // ************************************************************
  // power sequencer
  // ************************************************************
  seq_state_e state_reg, state_next;
  logic [15:0] tick_cnt_reg, ms_cnt_reg;
  logic [15:0] wait_target;

  wire ms_tick = (tick_cnt_reg == 16'(TICK_CYC - 1));
  wire wait_done = (ms_cnt_reg >= wait_target);
  wire vref_mode = enclk_reg[VREF_BIT];

  // boot waits the power-up delay, ramps wait the state delay
  assign wait_target = (state_reg == SEQ_BOOT) ?
    delay_reg[PUD_LSB +: 16] : {8'h00, delay_reg[STD_LSB +: 8]};

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SEQ_BOOT: if (wait_done) state_next = SEQ_STANDBY;
      SEQ_STANDBY: if (enable_req) state_next = SEQ_RAMP_UP;
      SEQ_RAMP_UP: begin
        if (!enable_req) state_next = SEQ_RAMP_DOWN;
        else if (vref_mode ? vref_stable : wait_done)
          state_next = SEQ_ON;
      end
      SEQ_ON: if (!enable_req) state_next = SEQ_RAMP_DOWN;
      SEQ_RAMP_DOWN: if (wait_done) state_next = SEQ_STANDBY;
    endcase
  end

  // timers restart on every state change so each wait counts from entry
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= SEQ_BOOT;
      tick_cnt_reg <= 16'h0000;
      ms_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || ms_tick) tick_cnt_reg <= 16'h0000;
      else tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      if (state_next != state_reg) ms_cnt_reg <= 16'h0000;
      else if (ms_tick && !wait_done) ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end

  // ************************************************************
  // decoded outputs
  // ************************************************************
  logic amp_en_reg, dev_en_reg, proc_clk_reg;
  logic div_ok_reg, short_on_reg, therm_on_reg;
  logic signed [8:0] adc_gain_reg, ser_gain_reg;
  logic [1:0] tx_src_reg;

  wire fault_hit = (short_fault && !analog_reg[SCOFF_BIT]) ||
    (thermal_fault && !analog_reg[THOFF_BIT]);
  wire silence_off = (analog_reg[ZANA_BIT] && !analog_present) ||
    (analog_reg[ZDIG_BIT] && !serial_present);
  wire amp_next = (state_reg == SEQ_ON) && !silence_off &&
    !(analog_reg[AUTOSD_BIT] && fault_hit);
  wire [1:0] tx_field = mixer_reg[TXSRC_LSB +: 2];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      amp_en_reg <= 1'b0;
      dev_en_reg <= 1'b0;
      proc_clk_reg <= 1'b1;
      adc_gain_reg <= 9'sh000;
      ser_gain_reg <= 9'sh000;
      tx_src_reg <= TX_NONE;
      div_ok_reg <= 1'b1;
      short_on_reg <= 1'b1;
      therm_on_reg <= 1'b1;
    end else begin
      amp_en_reg <= amp_next;
      dev_en_reg <= (state_reg == SEQ_ON);
      // configuration is complete once the sequencer reaches on
      proc_clk_reg <= !(enclk_reg[PCSTOP_BIT] && state_reg == SEQ_ON);
      adc_gain_reg <= gain_hdb(mixer_reg[ADCGAIN_LSB +: 6]);
      ser_gain_reg <= gain_hdb(mixer_reg[SERGAIN_LSB +: 6]);
      tx_src_reg <= (tx_field == TX_BAD) ? TX_NONE : tx_field;
      div_ok_reg <= (enclk_reg[PLLDIV_LSB +: 3] <= PLL_DIV_MAX);
      short_on_reg <= !analog_reg[SCOFF_BIT];
      therm_on_reg <= !analog_reg[THOFF_BIT];
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign amp_enable = amp_en_reg;
  assign dev_enabled = dev_en_reg;
  assign proc_clk_en = proc_clk_reg;
  assign pll_div_sel = enclk_reg[PLLDIV_LSB +: 3];
  assign pll_div_ok = div_ok_reg;
  assign pll_src_bclk = enclk_reg[PLLSRC_BIT];
  assign pmc_clk_ext = enclk_reg[PMCSEL_BIT];
  assign high_fidelity_mode = enclk_reg[HIGH_FIDELITY_MODE_BIT];
  assign adc_highpass_on = enclk_reg[HPFON_BIT];
  assign adc_highpass_mode = enclk_reg[HPFMODE_LSB +: 3];
  assign output_offset_correct = enclk_reg[OUTCORR_BIT];
  assign adc_offset_calibrate = enclk_reg[ADCCAL_BIT];
  assign adc_offset_correct = enclk_reg[ADCCORR_BIT];
  assign adc_gain_hdb = adc_gain_reg;
  assign serial_gain_hdb = ser_gain_reg;
  assign output_mute = mixer_reg[MUTE_BIT];
  assign zero_cross_off = mixer_reg[ZX_BIT];
  assign serial_to_dsp = mixer_reg[SER2DSP_BIT];
  assign adc_to_dsp = mixer_reg[ADC2DSP_BIT];
  assign transmitter_source = tx_src_reg;
  assign channel1_source = mixer_reg[CH1_LSB +: 2];
  assign channel2_source = mixer_reg[CH2_LSB +: 2];
  assign parallel_mode = analog_reg[PAR_BIT];
  assign single_edge_modulation = analog_reg[SEMOD_BIT];
  assign short_protect_on = short_on_reg;
  assign thermal_protect_on = therm_on_reg;
  assign adc_right_offset = adc_ofs_reg[15:0];
  assign adc_left_offset = adc_ofs_reg[31:16];
  assign channel1_offset = out_ofs_reg[15:0];
  assign channel2_offset = out_ofs_reg[31:16];
  assign sport_cfg = sport_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence mixer_zero_gain_wr;
    wr_mixer && reg_wdata[5:0] == 6'h33;
  endsequence

  manual_on_a: assert property (
    state_reg == SEQ_STANDBY && force_reg_src && enclk_reg[EN_BIT]
    |=> state_reg == SEQ_RAMP_UP)
    else $error("manual enable did not start power up");
  pin_off_a: assert property (
    state_reg == SEQ_ON && !force_reg_src && !pulse_mode && !pin_level_reg
    |=> state_reg == SEQ_RAMP_DOWN)
    else $error("low shutdown pin did not start power down");
  pulse_toggle_a: assert property (
    $rose(pin_level_reg) && $past(pulse_mode)
    |-> pulse_en_reg != $past(pulse_en_reg))
    else $error("pulse on shutdown pin did not toggle enable");
  vref_hold_a: assert property (
    state_reg == SEQ_RAMP_UP && vref_mode && !vref_stable && enable_req
    |=> state_reg == SEQ_RAMP_UP)
    else $error("sequencer left ramp before reference was stable");
  clk_stop_a: assert property (
    state_reg == SEQ_ON && enclk_reg[PCSTOP_BIT] |=> !proc_clk_en)
    else $error("processor clock still running after configuration");
  zero_gain_a: assert property (
    mixer_zero_gain_wr |=> ##1 adc_gain_hdb == 9'sh000)
    else $error("gain code 0x33 is not 0 dB");
  tx_unused_a: assert property (
    tx_field == TX_BAD |=> transmitter_source == TX_NONE)
    else $error("unused transmitter code selected a source");
  fault_off_a: assert property (
    analog_reg[AUTOSD_BIT] && short_fault && !analog_reg[SCOFF_BIT]
    |=> !amp_enable)
    else $error("amplifier stayed on during a short");
  comp_upper_a: assert property (
    reg_rd && reg_addr == OFS_COMP_OUT |=> reg_rdata[31:24] == 8'h00)
    else $error("compressor word upper bits not zero");
  unused_zero_a: assert property (
    (enclk_reg & ~ENCLK_MASK) == 32'h0 && (mixer_reg & ~MIXER_MASK) == 32'h0)
    else $error("unused bits hold a written value");

endmodule // amp_dsp_config_debug_regs
`default_nettype wire

// ### dv/amp_dsp_config_debug_regs_tb_top.sv
/*
  Self-checking bench for the amplifier configuration register bank.
  Assumes amp_cfg_pkg and the bank compiled first; drives the word strobe
  port and status pins itself, with no partner model.
*/
`timescale 1ns/1ps
`default_nettype none
module amp_dsp_config_debug_regs_tb_top
  import amp_cfg_pkg::*;
;
  logic clk_sys, nrst, shutdown_n_pin, reg_wr, reg_rd, reg_rd_valid;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, filt_dbg_in, acc_lo_in, acc_hi_in;
  logic [23:0] comp_in;
  logic [127:0] stat_in;
  logic vref_stable, analog_present, serial_present, short_fault;
  logic thermal_fault, amp_enable, dev_enabled, proc_clk_en, pll_div_ok;
  logic pll_src_bclk, pmc_clk_ext, high_fidelity_mode, adc_highpass_on;
  logic output_offset_correct, adc_offset_calibrate, adc_offset_correct;
  logic output_mute, zero_cross_off, serial_to_dsp, adc_to_dsp;
  logic parallel_mode, single_edge_modulation, short_protect_on;
  logic thermal_protect_on;
  logic [2:0] pll_div_sel, adc_highpass_mode;
  logic signed [8:0] adc_gain_hdb, serial_gain_hdb;
  logic [1:0] transmitter_source, channel1_source, channel2_source;
  logic [15:0] adc_right_offset, adc_left_offset;
  logic [15:0] channel1_offset, channel2_offset;
  logic [31:0] sport_cfg, w1, w2, w3, w4, w5, w6, exp_q[$], ro_e[9];
  logic [11:0] ro_a[9];
  logic [1:0] tx;
  int fail_count = 0, samples_checked = 0, cycles = 0, seed, i, g;

  // small tick so a millisecond is four clocks
  amp_dsp_config_debug_regs #(.TICK_CYC(4)) DUT (.*);

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk_out(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, exp);
    chk_out(got, exp, "read data");
  endtask

  // strobes stay up between calls so back-to-back access works
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_rd = 1'b0; reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_wr = 1'b0; reg_rd = 1'b1; reg_addr = a;
    @(negedge clk_sys);
  endtask

  task automatic idle;
    reg_wr = 1'b0; reg_rd = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic wait_en(input logic want);
    for (int k = 0; k < 300 && dev_enabled !== want; k++) @(negedge clk_sys);
  endtask

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // read monitor and hang guard
  // ****************************************
  always @(negedge clk_sys) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk_out(reg_rdata, 32'h0, "unexpected read");
      else chk_word(reg_rdata, exp_q.pop_front());
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      conclude;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 38;
    nrst = 1'b0; shutdown_n_pin = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 12'h000; reg_wdata = 32'h0; vref_stable = 1'b0;
    analog_present = 1'b1; serial_present = 1'b1;
    short_fault = 1'b0; thermal_fault = 1'b0;
    filt_dbg_in = $random(seed); acc_lo_in = $random(seed);
    acc_hi_in = $random(seed); comp_in = 24'($random(seed));
    stat_in = {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    rd(OFS_DELAY, DELAY_RST);
    rd(OFS_ENCLK, CFG_RST);
    idle;
    chk_out(proc_clk_en, 1'b1, "clock after reset");
    $display("test reset values done");
    for (i = 0; i < 8; i++) begin
      w1 = $random(seed) & 32'hFFFF_FFF0;
      w2 = $random(seed);
      w3 = $random(seed);
      w4 = $random(seed);
      w5 = $random(seed);
      w6 = $random(seed);
      wr(OFS_ENCLK, w1);
      rd(OFS_ENCLK, w1 & ENCLK_MASK);
      wr(OFS_ANALOG, w2);
      wr(OFS_MIXER, w3);
      wr(OFS_ADC_OFS, w4);
      wr(OFS_OUT_OFS, w5);
      wr(OFS_SPORT, w6);
      rd(OFS_ANALOG, w2 & ANALOG_MASK);
      rd(OFS_MIXER, w3 & MIXER_MASK);
      rd(OFS_ADC_OFS, w4);
      rd(OFS_OUT_OFS, w5);
      rd(OFS_SPORT, w6 & SPORT_MASK);
      idle;
      chk_out({pll_div_sel, pll_src_bclk, pmc_clk_ext, high_fidelity_mode},
              {w1[10:8], w1[11], w1[12], w1[13]}, "clock fields");
      chk_out(pll_div_ok, w1[10:8] <= 3'h4, "divider valid");
      chk_out({adc_highpass_on, adc_highpass_mode, output_offset_correct,
              adc_offset_calibrate, adc_offset_correct}, {w1[19],
              w1[18:16], w1[4], w1[5], w1[6]}, "adc fields");
      g = (int'(w3[5:0]) - 51) * 3;
      chk_out(adc_gain_hdb, 9'(g), "adc gain");
      g = (int'(w3[13:8]) - 51) * 3;
      chk_out(serial_gain_hdb, 9'(g), "serial gain");
      tx = (w3[19:18] == TX_BAD) ? TX_NONE : w3[19:18];
      chk_out({output_mute, zero_cross_off, serial_to_dsp, adc_to_dsp, tx},
              {w3[6], w3[7], w3[16], w3[17], transmitter_source},
              "mixer bits");
      chk_out({channel1_source, channel2_source}, {w3[25:24], w3[27:26]},
              "routing");
      chk_out({parallel_mode, single_edge_modulation, short_protect_on,
              thermal_protect_on}, {w2[2], w2[12], !w2[9], !w2[10]},
              "analog bits");
      chk_out({adc_left_offset, adc_right_offset}, w4, "adc offs");
      chk_out({channel2_offset, channel1_offset}, w5, "out offs");
      chk_out(sport_cfg, w6 & SPORT_MASK, "port word");
    end
    w1 = $random(seed);
    wr(OFS_DELAY, w1);
    rd(OFS_DELAY, w1);
    wr(OFS_DELAY, 32'h0200_0001);
    $display("test register fields done");
    ro_a = '{OFS_FILT_DBG, OFS_ACC_LO, OFS_ACC_HI, OFS_COMP_OUT, OFS_STAT0,
             OFS_STAT1, OFS_STAT2, OFS_STAT3, 12'h525};
    ro_e = '{filt_dbg_in, acc_lo_in, acc_hi_in, {8'h00, comp_in},
             stat_in[31:0], stat_in[63:32], stat_in[95:64], stat_in[127:96],
             32'h0};
    for (i = 0; i < 9; i++) begin
      wr(ro_a[i], 32'hFFFF_FFFF);
      rd(ro_a[i], ro_e[i]);
    end
    idle;
    $display("test read-only words done");
    wr(OFS_ANALOG, 32'h0);
    wr(OFS_ENCLK, 32'h0);
    idle;
    shutdown_n_pin = 1'b1;
    wait_en(1'b1);
    chk_out({dev_enabled, amp_enable}, 2'b11, "pin enable");
    shutdown_n_pin = 1'b0;
    wait_en(1'b0);
    chk_out(dev_enabled, 1'b0, "pin disable");
    wr(OFS_ENCLK, 32'h0000_000B);
    idle;
    repeat (60) @(negedge clk_sys);
    chk_out(dev_enabled, 1'b0, "waits on reference");
    vref_stable = 1'b1;
    wait_en(1'b1);
    chk_out(dev_enabled, 1'b1, "register enable");
    wr(OFS_ENCLK, 32'h0000_400B);
    idle;
    @(negedge clk_sys);
    chk_out(proc_clk_en, 1'b0, "processor clock stop");
    wr(OFS_ANALOG, 32'h0000_0058);
    idle;
    analog_present = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_out(amp_enable, 1'b0, "silence shutdown");
    analog_present = 1'b1;
    serial_present = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_out(amp_enable, 1'b0, "serial silence shutdown");
    serial_present = 1'b1;
    short_fault = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_out(amp_enable, 1'b0, "fault shutdown");
    short_fault = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_out(amp_enable, 1'b1, "fault cleared");
    thermal_fault = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_out(amp_enable, 1'b0, "thermal shutdown");
    wr(OFS_ANALOG, 32'h0000_0458);
    idle;
    repeat (2) @(negedge clk_sys);
    chk_out(amp_enable, 1'b1, "thermal guard off");
    thermal_fault = 1'b0;
    wr(OFS_ENCLK, 32'h0000_0002);
    idle;
    wait_en(1'b0);
    chk_out(dev_enabled, 1'b0, "register disable");
    wr(OFS_ENCLK, 32'h0000_0004);
    idle;
    for (i = 0; i < 2; i++) begin
      shutdown_n_pin = 1'b1;
      repeat (5) @(negedge clk_sys);
      shutdown_n_pin = 1'b0;
      repeat (5) @(negedge clk_sys);
      wait_en(!i[0]);
      chk_out(dev_enabled, !i[0], "pulse toggles enable");
    end
    wr(OFS_MIXER, 32'h0000_3333);
    idle;
    chk_out({adc_gain_hdb, serial_gain_hdb}, 18'h0, "0 dB code");
    $display("test sequencer done");
    repeat (3) @(negedge clk_sys);
    chk_out(exp_q.size(), 32'h0, "reads outstanding");
    conclude;
  end
endmodule // amp_dsp_config_debug_regs_tb_top
`default_nettype wire
